// ### rtl/status_map.vh
// Constants of the status reporting hierarchy: part codes, register indices,
// reset values and status byte bit positions.
// Assumes inclusion by bare name from the design files.
`ifndef STATUS_MAP_VH
`define STATUS_MAP_VH

// ---------------------------------------------------------------------------
// Access address layout: {register index[2:0], part code[2:0]}
// ---------------------------------------------------------------------------
`define ADDR_W 6
`define PART_W 3
`define PART_CONDITION 3'h0
`define PART_RISE_FILTER 3'h1
`define PART_FALL_FILTER 3'h2
`define PART_LATCHED_EVENTS 3'h3
`define PART_SUMMARY_MASK 3'h4

`define REG_LIMIT 3'h0
`define REG_QUES 3'h1
`define REG_OPER 3'h2
`define REG_ESR 3'h3
`define REG_STB 3'h4

// ---------------------------------------------------------------------------
// Widths and reset values
// ---------------------------------------------------------------------------
`define PART_W16 16
`define RISE_FILTER_RST 15'h7fff
`define FALL_FILTER_RST 15'h0000
`define SUMMARY_MASK_RST 15'h0000
`define SRE_RST 8'h00

// ---------------------------------------------------------------------------
// Status byte bits and the questionable bit of the limit summary
// ---------------------------------------------------------------------------
`define STB_ERRQ_BIT 2
`define STB_QUES_BIT 3
`define STB_MAV_BIT 4
`define STB_ESB_BIT 5
`define STB_MSS_BIT 6
`define STB_OPER_BIT 7
`define STB_MSS_MASK 8'h40
`define QUES_LIMIT_BIT 9

`endif

// ### rtl/sync_bits.v
// Two-stage synchroniser for a vector of independent level inputs.
// Assumes each bit is a slow level; no bus coherency is implied.
`default_nettype none

module sync_bits #(
    parameter WIDTH = 8
) (
    input wire clock,             // System clock
    input wire rstn,              // Asynchronous reset, active low
    input wire [WIDTH-1:0] din,   // Asynchronous levels
    output wire [WIDTH-1:0] dout  // Synchronised levels
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;
endmodule // sync_bits

`default_nettype wire

// ### rtl/status_reg.v
// One five-part status register: condition, rise and fall filters,
// latched events and summary mask, with its summary bit.
// Assumes condition inputs are already on the clock domain.
`default_nettype none
`include "status_map.vh"

module status_reg (
    input wire clock,                // System clock
    input wire rstn,                 // Asynchronous reset, active low
    input wire [14:0] cond,          // Live condition bits
    input wire wr,                   // Write strobe for this register
    input wire rd,                   // Read strobe for this register
    input wire [2:0] part,           // Part code
    input wire [15:0] wdata,         // Write data
    output reg [15:0] rdata,         // Read data of the selected part
    output wire summary              // Summary bit
);
    reg [14:0] rise_r;
    reg [14:0] fall_r;
    reg [14:0] mask_r;
    reg [14:0] event_r;
    reg [14:0] prev_r;
    wire [14:0] caught;
    wire [14:0] event_nxt;

    // Each bit position is filtered on its own
    assign caught = (cond & ~prev_r & rise_r) | (~cond & prev_r & fall_r); // RQ2 RQ6 RQ7
    // A read clears, but an event caught in the same cycle survives
    assign event_nxt = ((rd && part == `PART_LATCHED_EVENTS) ? 15'h0000 : event_r)
                       | caught; // RQ9 RQ10 RQ20
    assign summary = |(event_r & mask_r); // RQ11

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rise_r <= `RISE_FILTER_RST;
            fall_r <= `FALL_FILTER_RST;
            mask_r <= `SUMMARY_MASK_RST;
            event_r <= 15'h0000;
            prev_r <= 15'h0000;
        end else begin
            prev_r <= cond;
            event_r <= event_nxt;
            if (wr && part == `PART_RISE_FILTER) rise_r <= wdata[14:0]; // RQ8
            if (wr && part == `PART_FALL_FILTER) fall_r <= wdata[14:0]; // RQ8
            if (wr && part == `PART_SUMMARY_MASK) mask_r <= wdata[14:0]; // RQ12
        end
    end

    // Top bit reads as zero in every part
    always @* begin
        case (part)
            `PART_CONDITION: rdata = {1'b0, cond}; // RQ3 RQ5
            `PART_RISE_FILTER: rdata = {1'b0, rise_r}; // RQ3
            `PART_FALL_FILTER: rdata = {1'b0, fall_r}; // RQ3
            `PART_LATCHED_EVENTS: rdata = {1'b0, event_r}; // RQ3
            `PART_SUMMARY_MASK: rdata = {1'b0, mask_r}; // RQ1 RQ3
            default: rdata = 16'h0000;
        endcase
    end
endmodule // status_reg

`default_nettype wire

// ### rtl/status_hierarchy.v
// Hierarchical status reporting: limit, questionable, operation and
// standard event registers feeding the status byte and service request.
// Assumes hardware status pins are asynchronous; access strobes are
// synchronous one-cycle pulses from the remote-control logic.
//
// Operation
// (RQ1) Five sixteen-bit parts per register
// (RQ2) One source, same bit in all parts
// (RQ3) Top bit of every part reads zero
// (RQ4) Condition follows hardware or lower summary
// (RQ5) Condition is read-only, reads change nothing
// (RQ6) Rise sets event if rise filter set
// (RQ7) Fall sets event if fall filter set
// (RQ8) Edge filters freely readable and writable
// (RQ9) Events latch filtered transitions until read
// (RQ10) Event part read-only, read clears all
// (RQ11) Summary is OR of events AND mask
// (RQ12) Summary mask freely readable and writable
// (RQ13) Summary drives a bit of higher condition
// (RQ14) Summaries propagate automatically to service request
// (RQ15) Status byte gathers event, operation, questionable summaries
// (RQ16) Request mask enables status byte bits
// (RQ17) Message-available bit follows output buffer
// (RQ18) Mask bit six ignored; rise raises request
// (RQ19) Status byte bit four means message waiting
// (RQ20) New event survives simultaneous read clear
`default_nettype none
`include "status_map.vh"

module status_hierarchy (
    input wire clock,                 // System clock, 100 MHz
    input wire rstn,                  // Asynchronous reset, active low
    input wire [14:0] hw_limit,       // Limit-check status levels
    input wire [14:0] hw_ques,        // Questionable status levels
    input wire [14:0] hw_oper,        // Operation status levels
    input wire [14:0] hw_esr,         // Standard event status levels
    input wire err_queue_nempty,      // Error queue holds an entry
    input wire msg_avail,             // Output buffer holds a response
    input wire acc_wr,                // Write strobe
    input wire acc_rd,                // Read strobe
    input wire [5:0] acc_addr,        // {register index, part code}
    input wire [15:0] acc_wdata,      // Write data
    output reg [15:0] acc_rdata,      // Read data
    output reg acc_rvalid,            // Read data valid pulse
    output reg [7:0] stb,             // Status byte
    output reg mss,                   // Master summary
    output reg srq                    // Service request pulse
);
    // -----------------------------------------------------------------------
    // Address decode
    // -----------------------------------------------------------------------
    function hit;
        input [5:0] addr;
        input [2:0] idx;
        begin
            hit = (addr[5:3] == idx);
        end
    endfunction

    // -----------------------------------------------------------------------
    // Input synchronisation
    // -----------------------------------------------------------------------
    wire [61:0] sync_in;
    wire [61:0] sync_out;
    assign sync_in = {msg_avail, err_queue_nempty, hw_esr, hw_oper, hw_ques, hw_limit};

    sync_bits #(
        .WIDTH(62)
    ) u_sync (
        .clock(clock),
        .rstn(rstn),
        .din(sync_in),
        .dout(sync_out)
    );

    wire errq_s;
    wire mav_s;
    assign errq_s = sync_out[60];
    assign mav_s = sync_out[61];

    // -----------------------------------------------------------------------
    // Condition routing
    // -----------------------------------------------------------------------
    wire [3:0] summary;
    reg [59:0] cond_vec;

    always @* begin
        cond_vec = sync_out[59:0]; // RQ4
        // Limit register summary replaces one questionable condition bit
        cond_vec[15 + `QUES_LIMIT_BIT] = summary[0]; // RQ13 RQ14
    end

    // -----------------------------------------------------------------------
    // Five-part registers
    // -----------------------------------------------------------------------
    wire [63:0] part_rdata;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_reg
            status_reg u_reg (
                .clock(clock),
                .rstn(rstn),
                .cond(cond_vec[gi*15 +: 15]),
                .wr(acc_wr && hit(acc_addr, gi[2:0])),
                .rd(acc_rd && hit(acc_addr, gi[2:0])),
                .part(acc_addr[2:0]),
                .wdata(acc_wdata),
                .rdata(part_rdata[gi*16 +: 16]),
                .summary(summary[gi])
            );
        end
    endgenerate

    // -----------------------------------------------------------------------
    // Status byte and request mask
    // -----------------------------------------------------------------------
    reg [7:0] sre_r;
    reg [7:0] req_prev_r;
    reg [7:0] stb_low;
    wire [7:0] req_bits;
    wire mss_nxt;

    always @* begin
        stb_low = 8'h00;
        stb_low[`STB_ERRQ_BIT] = errq_s;
        stb_low[`STB_QUES_BIT] = summary[1]; // RQ15
        stb_low[`STB_MAV_BIT] = mav_s; // RQ17 RQ19
        stb_low[`STB_ESB_BIT] = summary[3]; // RQ15
        stb_low[`STB_OPER_BIT] = summary[2]; // RQ15
    end

    // Mask bit six never takes part
    assign req_bits = stb_low & sre_r & ~`STB_MSS_MASK; // RQ16 RQ18
    assign mss_nxt = |req_bits; // RQ14

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sre_r <= `SRE_RST;
            req_prev_r <= 8'h00;
            stb <= 8'h00;
            mss <= 1'b0;
            srq <= 1'b0;
        end else begin
            if (acc_wr && hit(acc_addr, `REG_STB) && acc_addr[2:0] == `PART_SUMMARY_MASK) begin
                sre_r <= acc_wdata[7:0]; // RQ16
            end
            req_prev_r <= req_bits;
            stb <= stb_low | (mss_nxt ? `STB_MSS_MASK : 8'h00);
            mss <= mss_nxt;
            srq <= |(req_bits & ~req_prev_r); // RQ18
        end
    end

    // -----------------------------------------------------------------------
    // Read path
    // -----------------------------------------------------------------------
    reg [15:0] rdata_nxt;

    always @* begin
        case (acc_addr[5:3])
            `REG_LIMIT: rdata_nxt = part_rdata[15:0];
            `REG_QUES: rdata_nxt = part_rdata[31:16];
            `REG_OPER: rdata_nxt = part_rdata[47:32];
            `REG_ESR: rdata_nxt = part_rdata[63:48];
            `REG_STB: begin
                if (acc_addr[2:0] == `PART_CONDITION)
                    rdata_nxt = {8'h00, stb_low | (mss_nxt ? `STB_MSS_MASK : 8'h00)};
                else if (acc_addr[2:0] == `PART_SUMMARY_MASK)
                    rdata_nxt = {8'h00, sre_r};
                else
                    rdata_nxt = 16'h0000;
            end
            default: rdata_nxt = 16'h0000;
        endcase
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            acc_rdata <= 16'h0000;
            acc_rvalid <= 1'b0;
        end else begin
            acc_rvalid <= acc_rd;
            if (acc_rd) acc_rdata <= rdata_nxt; // RQ3
        end
    end
endmodule // status_hierarchy

`default_nettype wire

// ### bench/status_hierarchy_sva.sv
// Checker of the status hierarchy top ports: read answers, status byte levels.
// Assumes one clock domain and an asynchronous active-low reset.
`default_nettype none
module status_hierarchy_sva (
    input wire clock,             // System clock
    input wire rstn,              // Reset, active low
    input wire err_queue_nempty,  // Error queue level
    input wire msg_avail,         // Output buffer level
    input wire acc_rd,            // Read strobe
    input wire [15:0] acc_rdata,  // Read data
    input wire acc_rvalid,        // Read data valid
    input wire [7:0] stb,         // Status byte
    input wire mss,               // Master summary
    input wire srq                // Service request pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_read_answered: assert property (acc_rd |=> acc_rvalid)
        else $error("read strobe got no answer");
    a_answer_cause: assert property (acc_rvalid |-> $past(acc_rd))
        else $error("read answer without a read");
    a_top_bit_zero: assert property (acc_rvalid |-> !acc_rdata[15])
        else $error("top bit of a part read as one");
    a_rdata_held: assert property (!acc_rvalid |-> $stable(acc_rdata))
        else $error("read data moved without a read");
    a_mss_in_stb: assert property (stb[6] == mss)
        else $error("status byte bit six differs from master summary");
    a_srq_enabled: assert property (srq |-> mss)
        else $error("request raised without an enabled bit");
    a_mav_follows: assert property ($past(msg_avail, 3) == $past(msg_avail, 4)
        |-> stb[4] == $past(msg_avail, 3))
        else $error("message bit does not follow the output buffer");
    a_errq_follows: assert property ($past(err_queue_nempty, 3)
        == $past(err_queue_nempty, 4) |-> stb[2] == $past(err_queue_nempty, 3))
        else $error("error queue bit does not follow its level");
    c_request: cover property (srq);
    c_nonzero_read: cover property (acc_rvalid && acc_rdata != 16'h0000);
    c_ques_summary: cover property (stb[3] && mss);
endmodule // status_hierarchy_sva
bind status_hierarchy status_hierarchy_sva i_status_hierarchy_sva (.clock(clock),
    .rstn(rstn), .err_queue_nempty(err_queue_nempty), .msg_avail(msg_avail),
    .acc_rd(acc_rd), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .stb(stb),
    .mss(mss), .srq(srq));
`default_nettype wire

// ### bench/remote_ctrl.sv
// Remote controller model: one-cycle write and read strobes on the access port.
// Assumes strobes are sampled on the rising clock edge.
`default_nettype none
module remote_ctrl (
    input wire logic clock,             // System clock
    input wire logic [15:0] acc_rdata,  // Read data
    input wire logic acc_rvalid,        // Read data valid
    output var logic acc_wr,            // Write strobe
    output var logic acc_rd,            // Read strobe
    output var logic [5:0] acc_addr,    // Register and part
    output var logic [15:0] acc_wdata   // Write data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        acc_wr = 1'b0;
        acc_rd = 1'b0;
        acc_addr = 6'h00;
        acc_wdata = 16'h0000;
    end
    task automatic access(input logic w, input logic [5:0] a, input logic [15:0] d,
                          output logic [15:0] q, output logic ok);
        @(posedge clock);
        #1;
        acc_wr = w;
        acc_rd = !w;
        acc_addr = a;
        acc_wdata = d;
        @(posedge clock);
        #1;
        acc_wr = 1'b0;
        acc_rd = 1'b0;
        // Released lines show the inverse so stale values cannot pass
        acc_addr = ~a;
        acc_wdata = ~d;
        ok = w;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (acc_rvalid === 1'b1) ok = 1'b1;
            else @(posedge clock) #1;
        end
        q = acc_rdata;
    endtask
endmodule // remote_ctrl
`default_nettype wire

// ### bench/tb_status_hierarchy.sv
// Bench of the status hierarchy: drives status levels, compares with a model.
// Assumes the remote controller model performs every register access.
`default_nettype none
module tb_status_hierarchy;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rstn = 0, errq = 0, mav = 0, ok;
    logic [14:0] hw[4] = '{default: 15'h0000};
    logic acc_wr, acc_rd, acc_rvalid, mss, srq;
    logic [5:0] acc_addr;
    logic [15:0] acc_wdata, acc_rdata, q, d, rng = 16'h4ce7;
    logic [7:0] stb;
    int bad_count = 0, n_checks = 0, srq_n = 0, n0, b, a, e;
    int rise_m[4], fall_m[4];
    int sb[6] = '{3, 3, 7, 5, 2, 4};
    always #5 clock = ~clock;
    always @(posedge clock) if (srq === 1'b1) srq_n <= srq_n + 1;
    status_hierarchy i_status_hierarchy (.clock(clock), .rstn(rstn), .hw_limit(hw[0]),
        .hw_ques(hw[1]), .hw_oper(hw[2]), .hw_esr(hw[3]), .err_queue_nempty(errq),
        .msg_avail(mav), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
        .stb(stb), .mss(mss), .srq(srq));
    remote_ctrl i_remote_ctrl (.clock(clock), .acc_rdata(acc_rdata),
        .acc_rvalid(acc_rvalid), .acc_wr(acc_wr), .acc_rd(acc_rd),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata));
    function automatic logic [15:0] rnd();
        rng = {rng[14:0], rng[15] ^ rng[13] ^ rng[12] ^ rng[10]};
        return rng;
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input int r, input int p, input logic [15:0] v);
        i_remote_ctrl.access(w, 6'(r * 8 + p), v, q, ok);
        if (!ok) begin
            bad_count++;
            give_verdict();
        end
    endtask
    task automatic rd(input int r, input int p, input logic [15:0] exp);
        acc(1'b0, r, p, 16'h0000);
        chk(q, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    initial begin
        tick(16);
        rstn = 1'b1;
        for (int r = 0; r < 4; r++) begin
            rd(r, 1, 16'h7fff);
            rd(r, 2, 16'h0000);
            rd(r, 4, 16'h0000);
            rd(r, 3, 16'h0000);
        end
        $display("test reset_values done");
        // ------------------------------------------------------------
        // Each source climbs to the status byte and the request line
        // ------------------------------------------------------------
        for (int s = 0; s < 6; s++) begin
            b = sb[s];
            if (s < 4) acc(1'b1, s, 4, 16'h0001);
            if (s == 0) acc(1'b1, 1, 4, 16'h0200);
            acc(1'b1, 4, 4, 16'h0040 | (16'h0001 << b));
            n0 = srq_n;
            if (s < 4) hw[s][0] = 1'b1;
            else if (s == 4) errq = 1'b1;
            else mav = 1'b1;
            tick(8);
            chk(stb[b], 16'h0001);
            chk(mss, 16'h0001);
            chk(16'(srq_n - n0), 16'h0001);
            acc(1'b1, 4, 4, 16'h0040);
            tick(3);
            chk(mss, 16'h0000);
            if (s < 4) hw[s][0] = 1'b0;
            errq = 1'b0;
            mav = 1'b0;
            tick(4);
            if (s < 4) rd(s, 3, 16'h0001);
            if (s == 0) rd(1, 3, 16'h0200);
            if (s < 4) rd(s, 3, 16'h0000);
            tick(4);
            chk(stb[b], 16'h0000);
            if (s < 4) acc(1'b1, s, 4, 16'h0000);
            if (s == 0) acc(1'b1, 1, 4, 16'h0000);
        end
        $display("test hierarchy done");
        // ------------------------------------------------------------
        // Random filters, masks and transitions against the model
        // ------------------------------------------------------------
        for (int n = 0; n < 24; n++) begin
            int r;
            r = n % 4;
            a = hw[r];
            d = rnd();
            acc(1'b1, r, 1, d);
            rise_m[r] = d & 16'h7fff;
            d = rnd();
            acc(1'b1, r, 2, d);
            fall_m[r] = d & 16'h7fff;
            d = rnd();
            acc(1'b1, r, 4, d);
            rd(r, 4, d & 16'h7fff);
            acc(1'b1, r, 4, 16'h0000);
            acc(1'b1, r, 0, rnd());
            acc(1'b1, r, 3, 16'hffff);
            d = rnd() & 16'h7dff;
            hw[r] = d[14:0];
            e = (~a & d & rise_m[r]) | (a & ~d & fall_m[r]);
            tick(5);
            chk(stb, 16'h0000);
            rd(r, 1, 16'(rise_m[r]));
            rd(r, 2, 16'(fall_m[r]));
            rd(r, 0, d);
            rd(r, 3, 16'(e));
            rd(r, 3, 16'h0000);
            rd(r, 0, d);
        end
        $display("test filters_events done");
        // ------------------------------------------------------------
        // An edge caught at the clearing read survives it
        // ------------------------------------------------------------
        acc(1'b1, 2, 1, 16'h0001);
        acc(1'b1, 2, 2, 16'h0000);
        hw[2] = 15'h0000;
        tick(4);
        rd(2, 3, 16'h0000);
        hw[2][0] = 1'b1;
        tick(1);
        rd(2, 3, 16'h0000);
        rd(2, 3, 16'h0001);
        rd(2, 3, 16'h0000);
        $display("test read_clear_race done");
        give_verdict();
    end
endmodule // tb_status_hierarchy
`default_nettype wire
